// >>> inc/adc_ctl_pkg.sv
// Shared constants and types for the converter alarm and sequencing logic.
// Assumes a 10 MHz core clock and a plain one-cycle register port.
package adc_ctl_pkg;
  // Widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int RES_W  = 12;
  localparam int CH_W   = 4;
  localparam int MON_CH = 4;
  localparam int NUM_RESULTS = 9;
  localparam logic [CH_W-1:0] TEMP_CH = 4'h8;

  // Register offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL        = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 8'h01;
  localparam logic [ADDR_W-1:0] REG_ALARM       = 8'h02;
  localparam logic [ADDR_W-1:0] REG_GPIO_CFG    = 8'h03;
  localparam logic [ADDR_W-1:0] REG_RESULT_BASE = 8'h10;

  // Control register field positions and reset value.
  localparam int CTRL_FIRST_LSB  = 0;
  localparam int CTRL_LAST_LSB   = 4;
  localparam int CTRL_AUTO_BIT   = 8;
  localparam int CTRL_REFSRC_BIT = 9;
  localparam int CTRL_REFLVL_BIT = 10;
  localparam int CTRL_EXT_BIT    = 11;
  localparam int CTRL_W          = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

  // Status register field positions.
  localparam int STAT_DRDY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // Timing: the auto-mode data-ready pulse.
  localparam int CLK_HZ        = 10_000_000;
  localparam int DRDY_PULSE_NS = 2000;
  localparam int DRDY_PULSE_CYC =
    (DRDY_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_W = 5;

  // Request to the converter core.
  typedef struct packed {
    logic            start;
    logic [CH_W-1:0] channel;
    logic            high_current_switch;
    logic            low_current_switch;
  } conv_req_t;

  // Answer from the converter core.
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] data;
  } conv_rsp_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} seq_state_t;
endpackage : adc_ctl_pkg

// >>> logic/adc_alarm_tempsense_control.sv
// Converter sequencing, range alarms, data-ready handshake and reference
// selection. Assumes a converter core that answers each start with one
// done pulse, and a host that reads and writes over a one-cycle port.
// Contract
// - Only the first four channels of the group are range checked.
// - An out-of-window result sets that channel's alarm flag.
// - The global alarm output is low while any alarm flag is set.
// - Pins 0 to 3 can each show one monitored channel's alarm.
// - Each new trigger clears all alarm flags and the global alarm.
// - Reading a result clears the data-ready flag and, in direct mode, the output.
// - In auto mode the data-ready flag stays zero.
// - Reference source bit resets to internal; one disconnects it.
// - Reference level bit resets to the low level; one selects high.
// - With external reference the level bit has no effect.
// - Temperature channel converts twice: high then low current.
// - The temperature result is the difference, straight binary.
// - Direct mode measures temperature alone or within a group.
// - Direct mode sets the data-ready flag when the group is done.
// - Auto mode pulses data-ready low for two microseconds.
// - Channels are converted from first to last in order.
`timescale 1ns/1ns
module adc_alarm_tempsense_control
  import adc_ctl_pkg::*;
(
  // Clock and reset.
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  // Register port.
  input  wire logic [adc_ctl_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [adc_ctl_pkg::DATA_W-1:0] i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic      [adc_ctl_pkg::DATA_W-1:0] o_reg_rdata,
  // Trigger pin.
  input  wire logic                          i_ext_trigger,
  // Converter core.
  output adc_ctl_pkg::conv_req_t             o_conv_req,
  input  wire adc_ctl_pkg::conv_rsp_t        i_conv_rsp,
  // Window limits of the monitored channels.
  input  wire logic [adc_ctl_pkg::MON_CH-1:0][adc_ctl_pkg::RES_W-1:0]
                                             i_limit_low,
  input  wire logic [adc_ctl_pkg::MON_CH-1:0][adc_ctl_pkg::RES_W-1:0]
                                             i_limit_high,
  // Alarm and handshake pins.
  output logic                               o_global_alarm_n,
  output logic      [adc_ctl_pkg::MON_CH-1:0] o_gpio_alarm_sel,
  output logic      [adc_ctl_pkg::MON_CH-1:0] o_gpio_alarm,
  output logic                               o_data_ready_n,
  // Reference control.
  output logic                               o_ref_disconnect,
  output logic                               o_ref_level_2v5
);
  import adc_ctl_pkg::*;

  // True for the addresses of the result registers.
  function automatic logic is_result_addr(input logic [ADDR_W-1:0] a);
    return (a >= REG_RESULT_BASE) &&
           (a < REG_RESULT_BASE + ADDR_W'(NUM_RESULTS));
  endfunction : is_result_addr

  logic [CTRL_W-1:0]  ctrl;
  logic [MON_CH-1:0]  range_alarm_flag;
  logic [MON_CH-1:0]  gpio_cfg;
  logic               data_ready_flag;
  logic [PULSE_W-1:0] pulse_cnt;
  logic               ext_d;
  seq_state_t         state;
  logic [CH_W-1:0]    cur_ch;
  logic               temp_phase;
  logic [RES_W-1:0]   temp_first;
  logic [DATA_W-1:0]  reg_rd_q;
  logic               rd_result_q;
  logic [RES_W-1:0]   mem_rd_data;

  // Decoded control fields.
  wire [CH_W-1:0] group_first_channel = ctrl[CTRL_FIRST_LSB +: CH_W];
  wire [CH_W-1:0] group_last_channel  = ctrl[CTRL_LAST_LSB +: CH_W];
  wire ref_source_select  = ctrl[CTRL_REFSRC_BIT];
  wire internal_ref_level = ctrl[CTRL_REFLVL_BIT];
  wire ext_mode           = ctrl[CTRL_EXT_BIT];
  // Auto mode only exists with the internal trigger.
  wire auto_active        = ctrl[CTRL_AUTO_BIT] && !ext_mode;

  // Triggers: a control write in internal mode, or a pin rising edge in external mode.
  // Switching to external mode stops any running sequence.
  wire wr_ctrl     = i_reg_wr && (i_reg_addr == REG_CTRL);
  wire wr_gpio     = i_reg_wr && (i_reg_addr == REG_GPIO_CFG);
  wire int_trigger = wr_ctrl && !i_reg_wdata[CTRL_EXT_BIT];
  wire ext_rise    = ext_mode && i_ext_trigger && !ext_d;
  wire trigger     = int_trigger || ext_rise;
  wire abort       = wr_ctrl && i_reg_wdata[CTRL_EXT_BIT];
  wire [CH_W-1:0] trig_first = int_trigger ?
                    i_reg_wdata[CTRL_FIRST_LSB +: CH_W] : group_first_channel;

  // Converter answers; a temperature first phase only captures a value.
  wire conv_done  = (state == SEQ_WAIT) && i_conv_rsp.done &&
                    !trigger && !abort;
  wire is_temp    = (cur_ch == TEMP_CH);
  wire temp_cap   = conv_done && is_temp && !temp_phase;
  wire keep_phase = temp_phase && !(conv_done || trigger || abort);
  wire result_wr  = conv_done && !temp_cap;
  wire group_done = result_wr && (cur_ch == group_last_channel);
  // A negative difference saturates to zero rather than wrapping.
  wire [RES_W-1:0] temp_diff = (temp_first > i_conv_rsp.data) ?
                    temp_first - i_conv_rsp.data : '0;
  wire [RES_W-1:0] result_data = is_temp ? temp_diff : i_conv_rsp.data;

  // Range check on the first four channels of the group.
  wire [CH_W-1:0] mon_idx   = cur_ch - group_first_channel;
  wire            monitored = (mon_idx < CH_W'(MON_CH));
  wire [1:0]      mon_sel   = mon_idx[1:0];
  wire            out_of_range = (result_data < i_limit_low[mon_sel]) ||
                                 (result_data > i_limit_high[mon_sel]);
  wire            alarm_hit = result_wr && monitored && out_of_range;
  wire [MON_CH-1:0] alarm_set = alarm_hit ? (MON_CH'(1) << mon_sel) : '0;

  // Result reads clear the data-ready flag.
  wire rd_result = i_reg_rd && is_result_addr(i_reg_addr);
  wire [ADDR_W-1:0] rd_off = i_reg_addr - REG_RESULT_BASE;

  // Sequencer next state; a trigger restarts from the first channel.
  seq_state_t      next_state;
  logic [CH_W-1:0] next_ch;
  always_comb begin
    next_state = state;
    next_ch    = cur_ch;
    if (trigger) begin
      next_state = SEQ_START;
      next_ch    = trig_first;
    end else if (abort) begin
      next_state = SEQ_IDLE;
    end else begin
      case (state)
        SEQ_IDLE:  next_state = SEQ_IDLE;
        SEQ_START: next_state = SEQ_WAIT;
        SEQ_WAIT: begin
          if (temp_cap) begin
            next_state = SEQ_START;
          end else if (group_done) begin
            next_state = auto_active ? SEQ_START : SEQ_IDLE;
            next_ch    = group_first_channel;
          end else if (result_wr) begin
            next_state = SEQ_START;
            next_ch    = cur_ch + 4'h1;
          end
        end
        default: next_state = SEQ_IDLE;
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= SEQ_IDLE;
      cur_ch     <= '0;
      temp_phase <= 1'b0;
      temp_first <= '0;
      ext_d      <= 1'b0;
    end else begin
      state      <= next_state;
      cur_ch     <= next_ch;
      temp_phase <= temp_cap || keep_phase;
      ext_d      <= i_ext_trigger;
      if (temp_cap) begin
        temp_first <= i_conv_rsp.data;
      end
    end
  end

  // Control and pin configuration registers.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl     <= CTRL_RESET;
      gpio_cfg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= i_reg_wdata[CTRL_W-1:0];
      end
      if (wr_gpio) begin
        gpio_cfg <= i_reg_wdata[MON_CH-1:0];
      end
    end
  end

  // Alarm flags hold until the next trigger clears them.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      range_alarm_flag <= '0;
    end else if (trigger) begin
      range_alarm_flag <= '0;
    end else begin
      range_alarm_flag <= range_alarm_flag | alarm_set;
    end
  end

  // Data-ready flag: completion beats a clearing read in the same cycle.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_ready_flag <= 1'b0;
    end else if (auto_active) begin
      data_ready_flag <= 1'b0;
    end else if (group_done) begin
      data_ready_flag <= 1'b1;
    end else if (rd_result || trigger) begin
      data_ready_flag <= 1'b0;
    end
  end

  // Auto-mode pulse timer; a new group done restarts the full width.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_cnt <= '0;
    end else if (group_done && auto_active) begin
      pulse_cnt <= PULSE_W'(DRDY_PULSE_CYC);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 5'h01;
    end
  end

  // Pin and converter outputs.
  assign o_global_alarm_n = ~|range_alarm_flag;
  assign o_gpio_alarm_sel = gpio_cfg;
  assign o_gpio_alarm     = range_alarm_flag & gpio_cfg;
  assign o_data_ready_n   = !(data_ready_flag || (pulse_cnt != '0));
  assign o_ref_disconnect = ref_source_select;
  // The level bit only matters while the internal source is chosen.
  assign o_ref_level_2v5  = internal_ref_level && !ref_source_select;
  assign o_conv_req.start   = (state == SEQ_START);
  assign o_conv_req.channel = cur_ch;
  assign o_conv_req.high_current_switch =
           is_temp && !temp_phase && (state != SEQ_IDLE);
  assign o_conv_req.low_current_switch =
           is_temp && temp_phase && (state != SEQ_IDLE);

  // Results land in the memory as each channel completes.
  result_mem #(.DEPTH(16), .AW(CH_W), .W(RES_W)) u_results (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_wr_en    (result_wr),
    .i_wr_addr  (cur_ch),
    .i_wr_data  (result_data),
    .i_rd_addr  (rd_off[CH_W-1:0]),
    .o_rd_data  (mem_rd_data)
  );

  // Register read mux; data stand only in the cycle after the strobe.
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (i_reg_addr)
      REG_CTRL:     rd_mux = DATA_W'(ctrl);
      REG_STATUS:   rd_mux = DATA_W'({(state != SEQ_IDLE), data_ready_flag});
      REG_ALARM:    rd_mux = DATA_W'(range_alarm_flag);
      REG_GPIO_CFG: rd_mux = DATA_W'(gpio_cfg);
      default:      rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_rd_q    <= '0;
      rd_result_q <= 1'b0;
    end else begin
      reg_rd_q    <= i_reg_rd ? rd_mux : '0;
      rd_result_q <= rd_result;
    end
  end

  assign o_reg_rdata = rd_result_q ? DATA_W'(mem_rd_data) : reg_rd_q;

  // Checks on the alarm, handshake and sequencing behaviour.
  property p_trigger_clears;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      trigger |=> (range_alarm_flag == '0) && o_global_alarm_n;
  endproperty
  a_trigger_clears: assert property (p_trigger_clears)
    else $error("alarms not cleared by trigger");

  property p_alarm_sets;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      alarm_hit |=> range_alarm_flag[$past(mon_sel)] && !o_global_alarm_n;
  endproperty
  a_alarm_sets: assert property (p_alarm_sets)
    else $error("alarm flag or global alarm missed");

  property p_unmonitored;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (result_wr && !monitored) |=> $stable(range_alarm_flag);
  endproperty
  a_unmonitored: assert property (p_unmonitored)
    else $error("alarm changed on unmonitored channel");

  property p_global_level;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (range_alarm_flag != '0) && !trigger |=> !o_global_alarm_n;
  endproperty
  a_global_level: assert property (p_global_level)
    else $error("global alarm released without trigger");

  property p_read_clears;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      rd_result && !group_done |=> !data_ready_flag;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("result read left data ready set");

  property p_auto_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      auto_active |=> !data_ready_flag;
  endproperty
  a_auto_flag: assert property (p_auto_flag)
    else $error("data ready flag set in auto mode");

  property p_direct_done;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      group_done && !auto_active |=> data_ready_flag && !o_data_ready_n;
  endproperty
  a_direct_done: assert property (p_direct_done)
    else $error("direct completion not signalled");

  property p_auto_pulse;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      group_done && auto_active |=> !o_data_ready_n [*8];
  endproperty
  a_auto_pulse: assert property (p_auto_pulse)
    else $error("auto data ready pulse too short");

  property p_temp_switches;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      temp_cap |=> o_conv_req.low_current_switch &&
                   !o_conv_req.high_current_switch;
  endproperty
  a_temp_switches: assert property (p_temp_switches)
    else $error("temperature switches not swapped");

  property p_ext_ref;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ref_source_select |-> !o_ref_level_2v5 && o_ref_disconnect;
  endproperty
  a_ext_ref: assert property (p_ext_ref)
    else $error("level bit active with external reference");

  property p_step;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      result_wr && !group_done |=> cur_ch == $past(cur_ch) + 4'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("channel did not advance by one");

  c_auto_done: cover property (@(posedge i_core_clk)
    group_done && auto_active);
  c_direct_done: cover property (@(posedge i_core_clk)
    group_done && !auto_active);
  c_temp_result: cover property (@(posedge i_core_clk) result_wr && is_temp);
  c_alarm_hit: cover property (@(posedge i_core_clk) alarm_hit);
endmodule : adc_alarm_tempsense_control

// >>> logic/result_mem.sv
// Small result memory with one write port and a registered read port.
// Assumes the caller keeps addresses in range.
`timescale 1ns/1ns
module result_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int W     = 12
) (
  // Clock and reset.
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  // Write port.
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [W-1:0]  i_wr_data,
  // Read port.
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [W-1:0]  o_rd_data
);
  logic [W-1:0] mem [DEPTH];

  // The array has no reset so it maps to plain storage.
  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Read data leave through a register, one cycle after the address.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule : result_mem

// >>> test/conv_core_model.sv
// Behavioural converter core that answers each start with one done pulse.
// Assumes the control block keeps at most one conversion outstanding.
`timescale 1ns/1ns
module conv_core_model (
  // Clock and reset.
  input  wire logic                                  i_core_clk,
  input  wire logic                                  i_rst_n,
  // Settings from the bench.
  input  wire logic [4:0]                            i_delay,
  input  wire logic [8:0][adc_ctl_pkg::RES_W-1:0]    i_chan_val,
  input  wire logic [adc_ctl_pkg::RES_W-1:0]         i_temp_low,
  // Link to the control block.
  input  wire adc_ctl_pkg::conv_req_t                i_conv_req,
  output adc_ctl_pkg::conv_rsp_t                     o_conv_rsp
);
  import adc_ctl_pkg::*;
  logic [4:0]       cnt;
  logic             busy;
  logic [RES_W-1:0] val;
  // Outside done the data lines carry the inverse of the sample, so a late
  // capture in the design sees a wrong value rather than a lucky one.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
      cnt <= '0;
      val <= '0;
      o_conv_rsp <= '0;
    end else begin
      o_conv_rsp.done <= 1'b0;
      o_conv_rsp.data <= ~val;
      if (i_conv_req.start) begin
        busy <= 1'b1;
        cnt <= i_delay;
        // The diode voltage depends on which current switch is closed.
        if (i_conv_req.channel == TEMP_CH &&
            i_conv_req.low_current_switch) begin
          val <= i_temp_low;
        end else begin
          val <= i_chan_val[i_conv_req.channel];
        end
      end else if (busy && cnt == 5'h00) begin
        busy <= 1'b0;
        o_conv_rsp.done <= 1'b1;
        o_conv_rsp.data <= val;
      end else if (busy) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule : conv_core_model

// >>> test/tb.sv
// Self-checking bench for the converter alarm and data-ready control.
// Assumes the behavioural converter core in conv_core_model.sv.
`timescale 1ns/1ns
module tb;
  import adc_ctl_pkg::*;
  logic                         core_clk;
  logic                         rst_n;
  logic [ADDR_W-1:0]            reg_addr;
  logic [DATA_W-1:0]            reg_wdata;
  logic                         reg_wr;
  logic                         reg_rd;
  logic [DATA_W-1:0]            reg_rdata;
  logic                         ext_trigger;
  conv_req_t                    conv_req;
  conv_rsp_t                    conv_rsp;
  logic [MON_CH-1:0][RES_W-1:0] limit_low;
  logic [MON_CH-1:0][RES_W-1:0] limit_high;
  logic                         global_alarm_n;
  logic [MON_CH-1:0]            gpio_sel;
  logic [MON_CH-1:0]            gpio_alarm;
  logic                         data_ready_n;
  logic                         ref_disconnect;
  logic                         ref_level_2v5;
  logic [4:0]                   delay;
  logic [8:0][RES_W-1:0]        chan_val;
  logic [RES_W-1:0]             temp_low;
  logic [DATA_W-1:0]            rd_val;
  logic [1:0]                   sw_log[$];
  int                           err_count;
  int                           comparisons;
  int                           width;

  adc_alarm_tempsense_control u_adc_alarm_tempsense_control (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_ext_trigger(ext_trigger),
    .o_conv_req(conv_req), .i_conv_rsp(conv_rsp),
    .i_limit_low(limit_low), .i_limit_high(limit_high),
    .o_global_alarm_n(global_alarm_n), .o_gpio_alarm_sel(gpio_sel),
    .o_gpio_alarm(gpio_alarm), .o_data_ready_n(data_ready_n),
    .o_ref_disconnect(ref_disconnect), .o_ref_level_2v5(ref_level_2v5));

  conv_core_model u_conv_core_model (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_delay(delay),
    .i_chan_val(chan_val), .i_temp_low(temp_low),
    .i_conv_req(conv_req), .o_conv_rsp(conv_rsp));

  // A 100 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Switch phases are logged on the falling edge, away from flop updates.
  always @(negedge core_clk) begin
    if (conv_req.start && conv_req.channel == TEMP_CH) begin
      sw_log.push_back({conv_req.high_current_switch,
                        conv_req.low_current_switch});
    end
  end

  task automatic check(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe.
  task automatic reg_read(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp, input string name);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    check(name, exp, rd_val);
  endtask : reg_read

  // The first edge is let pass, so a level left over from the previous
  // group is not mistaken for the answer to a fresh trigger.
  task automatic wait_drdy(input logic lvl);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    while (data_ready_n !== lvl && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("data_ready_n", {15'h0000, lvl}, {15'h0000, data_ready_n});
  endtask : wait_drdy

  task automatic test_done;
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Cuts a hang short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    test_done;
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_trigger = 1'b0;
    limit_low = {4{12'h100}};
    limit_high = {4{12'h800}};
    delay = 5'h03;
    chan_val = '0;
    temp_low = 12'h120;
    err_count = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    check("ref_disconnect", 16'h0000, {15'h0000, ref_disconnect});
    check("ref_level_2v5", 16'h0000, {15'h0000, ref_level_2v5});
    check("global_alarm_n", 16'h0001, {15'h0000, global_alarm_n});
    reg_read(REG_CTRL, 16'h0000, "ctrl reset");
    reg_read(8'h07, 16'h0000, "unmapped");
    reg_write(REG_GPIO_CFG, 16'h000F);
    reg_read(REG_GPIO_CFG, 16'h000F, "gpio cfg");
    check("gpio_sel", 16'h000F, {12'h000, gpio_sel});
    // Group 1..6: slots 0..3 are channels 1..4, channels 5 and 6 unwatched.
    chan_val[1] = 12'h050;
    chan_val[2] = 12'h200;
    chan_val[3] = 12'h900;
    chan_val[4] = 12'h300;
    chan_val[5] = 12'hFFF;
    chan_val[6] = 12'h000;
    reg_write(REG_CTRL, 16'h0061);
    wait_drdy(1'b0);
    reg_read(REG_STATUS, 16'h0001, "status flag");
    reg_read(REG_ALARM, 16'h0005, "alarm flags");
    check("global_alarm_n", 16'h0000, {15'h0000, global_alarm_n});
    check("gpio_alarm", 16'h0005, {12'h000, gpio_alarm});
    reg_read(REG_RESULT_BASE + 8'h01, 16'h0050, "result");
    check("data_ready_n", 16'h0001, {15'h0000, data_ready_n});
    reg_read(REG_STATUS, 16'h0000, "status flag");
    for (int c = 2; c <= 6; c++) begin
      reg_read(REG_RESULT_BASE + 8'(c), {4'h0, chan_val[c]}, "result");
    end
    reg_write(REG_RESULT_BASE + 8'h02, 16'hABCD);
    reg_read(REG_RESULT_BASE + 8'h02, 16'h0200, "read-only result");
    // A new trigger clears the alarms before any result lands.
    chan_val[1] = 12'h200;
    chan_val[3] = 12'h200;
    reg_write(REG_CTRL, 16'h0061);
    repeat (2) @(posedge core_clk);
    #1;
    check("global_alarm_n", 16'h0001, {15'h0000, global_alarm_n});
    check("gpio_alarm", 16'h0000, {12'h000, gpio_alarm});
    wait_drdy(1'b0);
    reg_read(REG_ALARM, 16'h0000, "alarm flags");
    // Temperature alone, then inside a group.
    chan_val[8] = 12'h300;
    sw_log.delete();
    reg_write(REG_CTRL, 16'h0088);
    wait_drdy(1'b0);
    reg_read(REG_RESULT_BASE + 8'h08, 16'h01E0, "temp result");
    check("switch phases", 16'h0002, 16'(sw_log.size()));
    check("first phase", 16'h0002, {14'h0000, sw_log[0]});
    check("second phase", 16'h0001, {14'h0000, sw_log[1]});
    temp_low = 12'h100;
    reg_write(REG_CTRL, 16'h0086);
    wait_drdy(1'b0);
    reg_read(REG_RESULT_BASE + 8'h08, 16'h0200, "temp result");
    // Auto mode over channels 7 and 8; one slow group outlasts the pulse.
    delay = 5'h0F;
    reg_write(REG_CTRL, 16'h0187);
    wait_drdy(1'b0);
    width = 0;
    while (data_ready_n === 1'b0 && width < 100) begin
      @(posedge core_clk);
      #1;
      width++;
    end
    check("pulse width", DATA_W'(DRDY_PULSE_CYC), DATA_W'(width));
    reg_read(REG_STATUS, 16'h0002, "auto flag");
    // Stop, then trigger through the pin in external mode.
    reg_write(REG_CTRL, 16'h0800);
    wait_drdy(1'b1);
    chan_val[0] = 12'h400;
    @(posedge core_clk);
    ext_trigger <= 1'b1;
    repeat (2) @(posedge core_clk);
    ext_trigger <= 1'b0;
    wait_drdy(1'b0);
    reg_read(REG_RESULT_BASE, 16'h0400, "result");
    check("data_ready_n", 16'h0001, {15'h0000, data_ready_n});
    // Reference control, kept in external mode so nothing is triggered.
    reg_write(REG_CTRL, 16'h0C00);
    #1;
    check("ref_level_2v5", 16'h0001, {15'h0000, ref_level_2v5});
    check("ref_disconnect", 16'h0000, {15'h0000, ref_disconnect});
    reg_write(REG_CTRL, 16'h0E00);
    #1;
    check("ref_disconnect", 16'h0001, {15'h0000, ref_disconnect});
    check("ref_level_2v5", 16'h0000, {15'h0000, ref_level_2v5});
    reg_read(REG_CTRL, 16'h0E00, "ctrl");
    test_done;
  end
endmodule : tb
